// File: shared/flash_host_pkg.sv
// Purpose: Constants for the flash bus-operation host controller.
// Assumes: 25 MHz clock; high-voltage qualifiers are separate pins.
// Notes: Times are kept in their own unit; cycle counts derive from them.
// Overview of operation
// RULE1 - Device drives read data only while chip and output enable are low.
// RULE2 - Write cycle: chip enable low, write enable low, output enable high.
// RULE3 - Device latches address on the later falling edge of write or chip enable.
// RULE4 - Device latches data on the earlier rising edge of write or chip enable.
// RULE5 - Outputs float when output enable and write enable are both high.
// RULE6 - Chip enable high with idle controller gives standby with floating outputs.
// RULE7 - After 150 ns bus inactivity device enters pseudo-standby still driving outputs.
// RULE8 - High voltage on signature line with A1 low reads identification codes.
// RULE9 - Signature read gives manufacturer code for A0 low, device code for high.
// RULE10 - Identification codes are also readable after the id query instruction.
// RULE11 - Word mode upper byte reads zero; byte mode upper pins float.
// RULE12 - Protect: high voltage on signature line and output enable, block address up.
// RULE13 - Protect starts on write enable falling, held 100 us, ends on rise.
// RULE14 - Protect verify returns 01h for a protected block under the listed levels.
// RULE15 - Program or erase of a protected block is silently ignored.
// RULE16 - High voltage on reset pin temporarily unprotects all protected blocks.
// RULE17 - Returning reset pin to normal high restores earlier protection.
// RULE18 - Programmer protects every block before running unprotection.
// RULE19 - Unprotect: high voltage on signature, output, chip enable, A12 A15 high, 10 ms.
// RULE20 - Unprotect verify returns 00h for an unprotected block.
// RULE21 - Programmer verifies each block individually by its address.
// RULE22 - Byte mode: data pins 8 to 14 float, top pin is lowest address; the host never drives the top pin with an address bit.
// RULE23 - Power-up or supply lockout returns command interface to array read.
// RULE24 - High-voltage detection on each pin is a separate qualifier signal.
package flash_host_pkg;
  localparam int CLK_MHZ = 25;
  localparam int SETUP_NS = 40;
  localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int INACTIVE_NS = 150;
  localparam int INACTIVE_CYC = (INACTIVE_NS * CLK_MHZ + 999) / 1000;
  localparam int PROTECT_US = 100;
  localparam int PROTECT_CYC = PROTECT_US * CLK_MHZ;
  localparam int UNPROTECT_MS = 10;
  localparam int UNPROTECT_CYC = UNPROTECT_MS * 1000 * CLK_MHZ;
  localparam logic [7:0] VERIFY_PROTECTED = 8'h01;
  localparam logic [7:0] VERIFY_UNPROTECTED = 8'h00;
  localparam int BIT_A0 = 0;
  localparam int BIT_A1 = 1;
  localparam int BIT_A6 = 6;
  localparam int BIT_A12 = 12;
  localparam int BIT_A15 = 15;
  typedef enum logic [2:0] {
    OP_READ, OP_WRITE, OP_SIG_READ, OP_PROTECT, OP_UNPROTECT, OP_PROT_VERIFY,
    OP_UNPROT_VERIFY, OP_STANDBY
  } op_t;
endpackage

// File: src/flash_bus_host.sv
// Purpose: Host sequencer that drives the flash pins for one bus operation per request.
// Assumes: Request inputs are in the clock domain; data pin inputs arrive from outside.
// Notes: Long pulse counts are parameters so a simulation can shorten them.
`timescale 1ns/1ns
module flash_bus_host import flash_host_pkg::*; #(
  parameter int PROTECT_CYCLES = PROTECT_CYC,
  parameter int UNPROTECT_CYCLES = UNPROTECT_CYC
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // User request.
  input wire logic reqValid,
  input wire op_t reqOp,
  input wire logic [18:0] reqAddr,
  input wire logic [15:0] reqData,
  input wire logic byteMode,
  input wire logic tempUnprotect,
  output logic reqReady,
  output logic rspValid,
  output logic [15:0] rspData,
  output logic verifyPass,
  // Flash pins.
  output logic chipEnN,
  output logic outEnN,
  output logic writeEnN,
  output logic byteWordSel,
  output logic [18:0] addr,
  output logic [15:0] dqOut,
  output logic dqOe,
  input wire logic [15:0] dqIn,
  output logic chipEnHv,
  output logic outEnHv,
  output logic signatureAddressLineHv,
  output logic resetUnlockPinN,
  output logic resetUnlockPinHv
);
  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_ACTIVE, S_HOLD, S_DONE} state_t;
  state_t state_q;
  op_t op_q;
  // A single counter serves every phase; it is cleared on entry to setup, active and hold, but not on hold to done.
  logic [31:0] cnt_q;
  logic [15:0] dqMeta_q;
  logic [15:0] dqSync_q;
  logic [31:0] activeLen;
  // One flag per block address, set when that block is sent a protect pulse.
  // Cleared again by an unprotect, which leaves every block unprotected.
  localparam int BLOCKS = 1 << (19 - BIT_A12);
  logic [BLOCKS-1:0] protSeen_q;
  logic refuse;

  // Unprotecting an array with any block not yet protected is not allowed, so such a request is
  // retired as a no-op with a failed verify flag instead of reaching the pins.
  always_comb begin
    refuse = (reqOp == OP_UNPROTECT) && !(&protSeen_q); // RULE18
  end

  always_comb begin
    unique case (op_q)
      OP_PROTECT: activeLen = PROTECT_CYCLES; // RULE13
      OP_UNPROTECT: activeLen = UNPROTECT_CYCLES; // RULE19
      OP_READ, OP_SIG_READ, OP_PROT_VERIFY, OP_UNPROT_VERIFY: activeLen = INACTIVE_CYC;
      default: activeLen = SETUP_CYC;
    endcase
  end

  // Data pins are asynchronous to the clock; two stages before use.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dqMeta_q <= 16'h0000;
      dqSync_q <= 16'h0000;
    end else begin
      dqMeta_q <= dqIn;
      dqSync_q <= dqMeta_q;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      op_q <= OP_STANDBY;
      cnt_q <= 32'h0000_0000;
    end else begin
      unique case (state_q)
        S_IDLE: if (reqValid) begin
          op_q <= refuse ? OP_STANDBY : reqOp;
          cnt_q <= 32'h0000_0000;
          state_q <= ((reqOp == OP_STANDBY) || refuse) ? S_DONE : S_SETUP; // RULE18
        end
        S_SETUP: if (cnt_q + 32'h1 >= SETUP_CYC) begin
          cnt_q <= 32'h0000_0000;
          state_q <= S_ACTIVE;
        end else begin
          cnt_q <= cnt_q + 32'h1;
        end
        S_ACTIVE: if (cnt_q + 32'h1 >= activeLen) begin
          cnt_q <= 32'h0000_0000;
          state_q <= S_HOLD;
        end else begin
          cnt_q <= cnt_q + 32'h1;
        end
        // Hold keeps address and data still past the strobe rise.
        S_HOLD: if (cnt_q + 32'h1 >= SETUP_CYC) begin
          state_q <= S_DONE;
        end else begin
          cnt_q <= cnt_q + 32'h1;
        end
        S_DONE: state_q <= S_IDLE;
      endcase
    end
  end

  // Pin sequencing; address and high voltage set up before the strobe edges.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chipEnN <= 1'b1;
      outEnN <= 1'b1;
      writeEnN <= 1'b1;
      byteWordSel <= 1'b1;
      addr <= 19'h00000;
      dqOut <= 16'h0000;
      dqOe <= 1'b0;
      chipEnHv <= 1'b0;
      outEnHv <= 1'b0;
      signatureAddressLineHv <= 1'b0;
    end else if (state_q == S_IDLE && reqValid && refuse) begin
      chipEnN <= 1'b1; // RULE18
    end else if (state_q == S_IDLE && reqValid) begin
      // High-voltage qualifiers rise with the address so they settle before any strobe.
      byteWordSel <= ~byteMode; // RULE22
      addr <= reqAddr;
      dqOut <= reqData;
      dqOe <= (reqOp == OP_WRITE);
      chipEnN <= (reqOp == OP_STANDBY) || (reqOp == OP_UNPROTECT); // RULE6
      signatureAddressLineHv <= (reqOp != OP_READ) && (reqOp != OP_WRITE) &&
                                (reqOp != OP_STANDBY); // RULE8 RULE12 RULE24
      outEnHv <= (reqOp == OP_PROTECT) || (reqOp == OP_UNPROTECT); // RULE12
      chipEnHv <= (reqOp == OP_UNPROTECT); // RULE19
      outEnN <= 1'b1;
      writeEnN <= 1'b1;
      if (reqOp == OP_SIG_READ) begin
        addr[BIT_A1] <= 1'b0; // RULE8
      end
      if (reqOp == OP_PROT_VERIFY || reqOp == OP_UNPROT_VERIFY) begin
        addr[BIT_A0] <= 1'b0; // RULE14 RULE20
        addr[BIT_A1] <= 1'b1;
        addr[BIT_A6] <= (reqOp == OP_UNPROT_VERIFY);
      end
      if (reqOp == OP_UNPROTECT) begin
        addr[BIT_A12] <= 1'b1; // RULE19
        addr[BIT_A15] <= 1'b1;
      end
    end else if (state_q == S_SETUP && cnt_q + 32'h1 >= SETUP_CYC) begin
      // Write enable only falls once output enable is high.
      if (op_q == OP_WRITE || op_q == OP_PROTECT || op_q == OP_UNPROTECT) begin
        writeEnN <= 1'b0; // RULE2 RULE3 RULE13 RULE19
      end else begin
        outEnN <= 1'b0; // RULE1
      end
    end else if (state_q == S_ACTIVE && cnt_q + 32'h1 >= activeLen) begin
      writeEnN <= 1'b1; // RULE4 RULE13
      outEnN <= 1'b1; // RULE5
    end else if (state_q == S_DONE) begin
      // Chip enable rises last, after the write strobe, so data latching stays clean.
      chipEnN <= 1'b1;
      chipEnHv <= 1'b0;
      outEnHv <= 1'b0;
      signatureAddressLineHv <= 1'b0;
      dqOe <= 1'b0;
    end
  end

  // Read data sampled at the end of the enabled window.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rspValid <= 1'b0;
      rspData <= 16'h0000;
      verifyPass <= 1'b0;
      reqReady <= 1'b0;
    end else begin
      // Ready is informational only; requests made while busy are simply ignored.
      reqReady <= (state_q == S_IDLE) && !reqValid;
      rspValid <= (state_q == S_DONE);
      if (state_q == S_IDLE && reqValid && refuse) begin
        verifyPass <= 1'b0; // RULE18
      end
      if (state_q == S_HOLD && cnt_q == 32'h0000_0000) begin
        rspData <= byteWordSel ? dqSync_q : {8'h00, dqSync_q[7:0]}; // RULE11
        verifyPass <= (op_q == OP_PROT_VERIFY) ? (dqSync_q[7:0] == VERIFY_PROTECTED) :
                      (dqSync_q[7:0] == VERIFY_UNPROTECTED); // RULE14 RULE20 RULE21
      end
    end
  end

  // Block bookkeeping for the protect-all-before-unprotect order.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      protSeen_q <= {BLOCKS{1'b0}};
    end else if (state_q == S_IDLE && reqValid) begin
      if (reqOp == OP_PROTECT) begin
        protSeen_q[reqAddr[18:BIT_A12]] <= 1'b1; // RULE18
      end else if (reqOp == OP_UNPROTECT && !refuse) begin
        protSeen_q <= {BLOCKS{1'b0}};
      end
    end
  end

  // Temporary unprotection holds the reset pin at high voltage.
  // The reset pin never pulses low here; a hardware reset is outside this sequencer.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      resetUnlockPinN <= 1'b1;
      resetUnlockPinHv <= 1'b0;
    end else begin
      resetUnlockPinN <= 1'b1;
      resetUnlockPinHv <= tempUnprotect; // RULE16 RULE17
    end
  end
endmodule

// File: tb/flash_bus_host_props.sv
// Purpose: Port-level checks on the flash host sequencer.
// Assumes: One clock domain, reset async active high.
// Notes: Attached by bind at the foot of this file.
`timescale 1ns/1ns
module flash_bus_host_props (
  // Clock, reset and response.
  input wire logic clock, rst, rspValid,
  // Flash pins.
  input wire logic chipEnN, outEnN, writeEnN, dqOe,
  input wire logic chipEnHv, outEnHv, signatureAddressLineHv,
  input wire logic [18:0] addr,
  input wire logic [15:0] dqOut
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_write_levels: assert property (!writeEnN && !outEnHv |-> !chipEnN && outEnN)
    else $error("write strobe without chip enable or with output enable");
  a_no_contention: assert property (dqOe |-> outEnN)
    else $error("host drives data while output enable is low");
  a_read_quiet: assert property (!outEnN |-> writeEnN && !dqOe)
    else $error("read with write strobe or host drive");
  a_prot_levels: assert property (!writeEnN && outEnHv |-> signatureAddressLineHv)
    else $error("protect pulse without signature line high voltage");
  a_prot_width: assert property ($fell(writeEnN) && outEnHv && !chipEnHv |-> !writeEnN [*8])
    else $error("protect pulse too short");
  a_unprot_levels: assert property (!writeEnN && chipEnHv |->
      outEnHv && signatureAddressLineHv && addr[12] && addr[15])
    else $error("unprotect pulse with wrong levels");
  a_data_held: assert property ($rose(writeEnN) && !chipEnN && !outEnHv |->
      dqOe && $stable(dqOut) && $stable(addr))
    else $error("write data not held to the strobe rise");
  a_verify_addr: assert property (signatureAddressLineHv && !outEnN && addr[1] |->
      !addr[0] && writeEnN)
    else $error("verify read with wrong address bits");
  a_rsp_pulse: assert property (rspValid |=> !rspValid)
    else $error("response longer than one cycle");
endmodule
bind flash_bus_host flash_bus_host_props chk (.*);

// File: tb/flash_dev_model.sv
// Purpose: Behavioural flash device facing the host sequencer.
// Assumes: High-voltage levels arrive as separate qualifier pins.
// Notes: Undriven data pins show inverted data, never a stale steady value.
`timescale 1ns/1ns
module flash_dev_model #(
  parameter logic [15:0] MFR_ID = 16'h00A5, // Arbitrary value.
  parameter logic [15:0] DEV_ID = 16'h003C // Arbitrary value.
) (
  input wire logic chipEnN, outEnN, writeEnN, byteWordSel,
  input wire logic chipEnHv, outEnHv, signatureAddressLineHv, resetUnlockPinHv,
  input wire logic [18:0] addr,
  input wire logic [15:0] dqOut,
  output logic [15:0] dqIn
);
  logic [15:0] mem [int];
  bit [127:0] prot;
  logic [18:0] latA;
  logic [15:0] rd;
  bit idMode = 1'b0;
  always @* begin
    if (!signatureAddressLineHv && !idMode) rd = mem.exists(addr) ? mem[addr] : 16'hFFFF;
    else if (addr[1]) rd = {15'h0, prot[addr[18:12]]};
    else rd = addr[0] ? DEV_ID : MFR_ID;
  end
  // Byte mode floats the upper pins, so they must not look like valid zeros.
  // A long read keeps driving; the low-power idle state never floats the outputs.
  assign dqIn = (!chipEnN && !outEnN) ? (byteWordSel ? rd : {~rd[15:8], rd[7:0]}) : ~rd;
  always @(negedge writeEnN or negedge chipEnN) begin
    latA = addr;
    if (!writeEnN && chipEnHv && outEnHv && signatureAddressLineHv) prot = 128'h0;
  end
  always @(posedge writeEnN or posedge chipEnN) begin
    if (outEnHv && !chipEnHv && signatureAddressLineHv) prot[latA[18:12]] = 1'b1;
    else if ((writeEnN ^ chipEnN) && outEnN && !outEnHv && !chipEnHv) begin
      if (!prot[latA[18:12]] || resetUnlockPinHv) mem[latA] = dqOut;
      if (dqOut[7:0] == 8'h90) idMode = 1'b1;
      else if (dqOut[7:0] == 8'hF0) idMode = 1'b0;
    end
  end
endmodule

// File: tb/flash_bus_host_tb_top.sv
// Purpose: Self-checking bench for the flash host sequencer.
// Assumes: Pulse counts shortened to 10 cycles.
// Notes: Each scenario task drives and judges its own operations.
`timescale 1ns/1ns
module flash_bus_host_tb_top;
  import flash_host_pkg::*;
  localparam logic [15:0] MFR = 16'h00A5; // Arbitrary value.
  localparam logic [15:0] DEVC = 16'h003C; // Arbitrary value.
  logic clock = 0, rst = 1, reqValid = 0, byteMode = 0, tempUnprotect = 0;
  op_t reqOp = OP_READ;
  logic [18:0] reqAddr = 19'h0, addr;
  logic [15:0] reqData = 16'h0, rspData, dqOut, dqIn;
  logic reqReady, rspValid, verifyPass, chipEnN, outEnN, writeEnN, byteWordSel, dqOe;
  logic chipEnHv, outEnHv, signatureAddressLineHv, resetUnlockPinN, resetUnlockPinHv;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  flash_bus_host #(.PROTECT_CYCLES(10), .UNPROTECT_CYCLES(10)) uut (.*);
  flash_dev_model #(.MFR_ID(MFR), .DEV_ID(DEVC)) dev (.*);
  always #20 clock = ~clock;
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic op(op_t o, logic [18:0] a, logic [15:0] d = 16'h0, logic bm = 0, logic tu = 0);
    @(posedge clock);
    reqValid <= 1'b1;
    reqOp <= o;
    reqAddr <= a;
    reqData <= d;
    byteMode <= bm;
    tempUnprotect <= tu;
    @(posedge clock);
    reqValid <= 1'b0;
    @(negedge clock);
    while (rspValid !== 1'b1) @(negedge clock);
  endtask
  task automatic t_write_read;
    op(OP_WRITE, 19'h00123, 16'hA55A);
    op(OP_READ, 19'h00123);
    chk("word read", 16'hA55A, rspData);
    op(OP_READ, 19'h00123, 16'h0, 1'b1);
    chk("byte read", 16'h005A, rspData);
  endtask
  task automatic t_signature;
    op(OP_SIG_READ, 19'h7FFF0);
    chk("maker code", MFR, rspData);
    op(OP_SIG_READ, 19'h7FFF1);
    chk("part code", DEVC, rspData);
    op(OP_SIG_READ, 19'h00000, 16'h0, 1'b1);
    chk("byte maker code", MFR, rspData);
    op(OP_WRITE, 19'h00200, 16'h0090);
    op(OP_READ, 19'h00000);
    chk("query maker code", MFR, rspData);
    op(OP_WRITE, 19'h00200, 16'h00F0);
    op(OP_READ, 19'h00123);
    chk("array after query", 16'hA55A, rspData);
  endtask
  task automatic t_protect;
    op(OP_PROTECT, 19'h12000);
    op(OP_PROT_VERIFY, 19'h12000);
    chk("protect verify", 16'h1, {15'h0, verifyPass});
    op(OP_WRITE, 19'h12040, 16'h1234);
    op(OP_READ, 19'h12040);
    chk("locked write", 16'hFFFF, rspData);
    op(OP_WRITE, 19'h12040, 16'h1234, 1'b0, 1'b1);
    op(OP_READ, 19'h12040);
    chk("temp unlock write", 16'h1234, rspData);
    op(OP_PROT_VERIFY, 19'h12000);
    chk("relock verify", 16'h1, {15'h0, verifyPass});
    op(OP_UNPROTECT, 19'h12000);
    chk("early unprotect refused", 16'h0, {15'h0, verifyPass});
    op(OP_PROT_VERIFY, 19'h12000);
    chk("still protected", 16'h1, {15'h0, verifyPass});
    for (int b = 0; b < 128; b++) op(OP_PROTECT, {b[6:0], 12'h000});
    op(OP_UNPROTECT, 19'h12000);
    op(OP_UNPROT_VERIFY, 19'h12000);
    chk("unprotect verify", 16'h1, {15'h0, verifyPass});
    op(OP_UNPROT_VERIFY, 19'h7F000);
    chk("last block unprotected", 16'h1, {15'h0, verifyPass});
    op(OP_STANDBY, 19'h0);
    chk("standby chip enable", 16'h1, {15'h0, chipEnN});
    @(negedge clock);
    chk("ready when idle", 16'h1, {15'h0, reqReady});
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // The protect-all sweep takes about 1,920 cycles (128 protects of 15 cycles); the ceiling leaves ample margin.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_write_read();
    t_signature();
    t_protect();
    wrap_up();
  end
endmodule
